// ---- rtl/pci_target.sv ----
// Behaviour
// RULE1: All logic runs on the bus clock
// RULE2: Reset clears every register and output; frame_q, frame_n, irdy_n, trdy_n, stop_n, devsel_n reset high
// RULE3: Reset floats address/data and system error
// RULE4: Initiator puts address on lines first
// RULE5: Data moves only when both ready low
// RULE6: Frame low marks the address phase
// RULE7: Frame rises for the final data phase
// RULE8: Write irdy only with valid data
// RULE9: Read irdy means initiator takes data
// RULE10: Target ready only when phase completes
// RULE11: Stop asks initiator to end transaction
// RULE12: Device select after own address decode
// RULE13: Even parity, valid one clock later
// RULE14: Not addressed keeps drivers floating
`timescale 1ns/1ps
`default_nettype none

module pci_target
    import pci_pkg::*;
#(
    parameter logic [AD_W-1:0] BASE = IO_BASE_DEF,
    parameter int DEPTH = MEM_DEPTH_DEF
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ce,
    pci_if.target bus,
    input wire logic user_ready,
    input wire logic [$clog2(DEPTH)-1:0] user_addr,
    output logic [AD_W-1:0] user_rdata,
    output logic write_strobe,
    output logic addr_par_err,
    output logic data_par_err
);

    localparam int IW = $clog2(DEPTH);
    localparam logic [AD_W-1:0] SPAN_MASK = AD_W'(DEPTH * CBE_W - 1);
    localparam logic [IW-1:0] LAST = IW'(DEPTH - 1);

    typedef enum logic [2:0]
    {
        T_IDLE = 3'h0,
        T_DECODE = 3'h1,
        T_DATA = 3'h3,
        T_STOPW = 3'h2,
        T_TURN = 3'h6
    } tstate_t;

    typedef struct packed {
        tstate_t st;
        logic [DEPTH-1:0][AD_W-1:0] mem;
        logic [IW-1:0] idx;
        logic wr;
        logic frame_q;
        logic [AD_W-1:0] ad_out;
        logic ad_oe;
        logic trdy_n;
        logic stop_n;
        logic devsel_n;
        logic ctl_oe;
        logic par_out;
        logic par_oe;
        logic serr_oe;
        logic chk_addr;
        logic [AD_W-1:0] adr_lat;
        logic [CBE_W-1:0] cbe_lat;
        logic chk_data;
        logic [AD_W-1:0] wd_lat;
        logic [CBE_W-1:0] wbe_lat;
        logic [AD_W-1:0] rdata;
        logic wstb;
        logic aperr;
        logic dperr;
    } targ_reg_t;

    targ_reg_t r_reg;
    targ_reg_t r_next;
    logic addr_phase;
    logic hit;
    logic xfer;

    ////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        r_next = r_reg;
        r_next.wstb = 1'b0;
        r_next.aperr = 1'b0;
        r_next.dperr = 1'b0;
        r_next.serr_oe = 1'b0;
        r_next.chk_addr = 1'b0;
        r_next.chk_data = 1'b0;
        r_next.frame_q = bus.frame_n;
        r_next.rdata = r_reg.mem[user_addr];

        // RULE13: read parity one clock late
        r_next.par_out = even_par(r_reg.ad_out, bus.cbe_n);
        r_next.par_oe = r_reg.ad_oe;

        // RULE13: address parity check
        if (r_reg.chk_addr && (bus.par != even_par(r_reg.adr_lat, r_reg.cbe_lat)))
        begin
            r_next.aperr = 1'b1;
            r_next.serr_oe = 1'b1;
        end
        // RULE13: write data parity check
        if (r_reg.chk_data && (bus.par != even_par(r_reg.wd_lat, r_reg.wbe_lat)))
        begin
            r_next.dperr = 1'b1;
        end

        // RULE6: frame edge is address phase
        addr_phase = !bus.frame_n && r_reg.frame_q;
        hit = ((bus.ad & ~SPAN_MASK) == (BASE & ~SPAN_MASK)) &&
              ((bus.cbe_n == CMD_IO_RD) || (bus.cbe_n == CMD_IO_WR));
        // RULE5: both ready move data
        xfer = !bus.irdy_n && !r_reg.trdy_n;

        unique case (r_reg.st)
            T_IDLE:
            begin
                // RULE14: drivers released when idle
                r_next.ctl_oe = 1'b0;
                r_next.ad_oe = 1'b0;
                if (addr_phase)
                begin
                    r_next.adr_lat = bus.ad;
                    r_next.cbe_lat = bus.cbe_n;
                    r_next.chk_addr = 1'b1;
                    if (hit)
                    begin
                        // RULE12: select after decode
                        r_next.st = T_DECODE;
                        r_next.idx = bus.ad[WORD_SHIFT +: IW];
                        r_next.wr = bus.cbe_n == CMD_IO_WR;
                        r_next.devsel_n = 1'b0;
                        r_next.trdy_n = 1'b1;
                        r_next.stop_n = 1'b1;
                        r_next.ctl_oe = 1'b1;
                    end
                end
            end
            T_DECODE:
            begin
                r_next.st = T_DATA;
                r_next.ad_oe = !r_reg.wr;
                r_next.ad_out = r_reg.mem[r_reg.idx];
                // RULE10: ready only when able
                r_next.trdy_n = !user_ready;
            end
            T_DATA:
            begin
                if (xfer)
                begin
                    if (r_reg.wr)
                    begin
                        for (int b = 0; b < CBE_W; b++)
                        begin
                            if (!bus.cbe_n[b])
                            begin
                                r_next.mem[r_reg.idx][b*BYTE_W +: BYTE_W] = bus.ad[b*BYTE_W +: BYTE_W];
                            end
                        end
                        r_next.wstb = 1'b1;
                        r_next.wd_lat = bus.ad;
                        r_next.wbe_lat = bus.cbe_n;
                        r_next.chk_data = 1'b1;
                    end
                    // RULE7: frame high means last
                    if (bus.frame_n)
                    begin
                        r_next.st = T_TURN;
                        r_next.trdy_n = 1'b1;
                        r_next.devsel_n = 1'b1;
                        r_next.ad_oe = 1'b0;
                    end
                    else if (r_reg.idx == LAST)
                    begin
                        // RULE11: stop at end of window
                        r_next.st = T_STOPW;
                        r_next.trdy_n = 1'b1;
                        r_next.stop_n = 1'b0;
                        r_next.ad_oe = 1'b0;
                    end
                    else
                    begin
                        r_next.idx = r_reg.idx + 1'b1;
                        r_next.ad_out = r_reg.mem[r_reg.idx + 1'b1];
                        // RULE10: ready only when able
                        r_next.trdy_n = !user_ready;
                    end
                end
                else
                begin
                    r_next.trdy_n = !user_ready;
                end
            end
            T_STOPW:
            begin
                // RULE11: hold stop until frame ends
                if (bus.frame_n)
                begin
                    r_next.st = T_TURN;
                    r_next.stop_n = 1'b1;
                    r_next.devsel_n = 1'b1;
                end
            end
            T_TURN:
            begin
                // RULE14: float after one high cycle
                r_next.st = T_IDLE;
                r_next.ctl_oe = 1'b0;
            end
            default:
            begin
                r_next.st = T_IDLE;
                r_next.ctl_oe = 1'b0;
                r_next.ad_oe = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // RULE1: single bus clock
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            // RULE2: defined state on reset
            // RULE3: address/data and serr float
            r_reg <= '0;
            r_reg.st <= T_IDLE;
            r_reg.frame_q <= 1'b1;
            r_reg.trdy_n <= 1'b1;
            r_reg.stop_n <= 1'b1;
            r_reg.devsel_n <= 1'b1;
        end
        else if (ce)
        begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Pin drive
    assign bus.t_ad = r_reg.ad_out;
    assign bus.t_ad_oe = r_reg.ad_oe;
    assign bus.t_par = r_reg.par_out;
    assign bus.t_par_oe = r_reg.par_oe;
    assign bus.t_trdy_n = r_reg.trdy_n;
    assign bus.t_stop_n = r_reg.stop_n;
    assign bus.t_devsel_n = r_reg.devsel_n;
    assign bus.t_ctl_oe = r_reg.ctl_oe;
    assign bus.serr_oe = r_reg.serr_oe;
    assign user_rdata = r_reg.rdata;
    assign write_strobe = r_reg.wstb;
    assign addr_par_err = r_reg.aperr;
    assign data_par_err = r_reg.dperr;

endmodule

`default_nettype wire

// ---- rtl/pci_pkg.sv ----
package pci_pkg;

    // Bus geometry
    localparam int AD_W = 32;
    localparam int CBE_W = 4;
    localparam int BYTE_W = 8;
    localparam int WORD_SHIFT = 2;

    // Clocking, nominal bus rate and the rate this build runs at
    localparam int BUS_NOM_MHZ = 33;
    localparam int CLK_MHZ = 25;

    // Bus commands and byte enables
    localparam logic [CBE_W-1:0] CMD_IO_RD = 4'h2;
    localparam logic [CBE_W-1:0] CMD_IO_WR = 4'h3;
    localparam logic [CBE_W-1:0] BE_ALL = 4'h0;

    // Target defaults
    localparam logic [AD_W-1:0] IO_BASE_DEF = 32'h00001000;
    localparam int MEM_DEPTH_DEF = 8;

    // Initiator defaults
    localparam int BURST_W = 4;
    localparam int ABORT_W = 3;
    localparam logic [ABORT_W-1:0] ABORT_CYC = 3'h5;

    // Even parity across address/data and command/byte enables
    function automatic logic even_par(input logic [AD_W-1:0] ad, input logic [CBE_W-1:0] cbe);
        return ^{ad, cbe};
    endfunction

endpackage

// ---- rtl/pci_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface pci_if;
    import pci_pkg::*;

    // Initiator drives
    logic [AD_W-1:0] m_ad;
    logic m_ad_oe;
    logic [CBE_W-1:0] cbe_n;
    logic frame_n;
    logic irdy_n;
    logic m_par;
    logic m_par_oe;

    // Target drives
    logic [AD_W-1:0] t_ad;
    logic t_ad_oe;
    logic t_par;
    logic t_par_oe;
    logic t_trdy_n;
    logic t_stop_n;
    logic t_devsel_n;
    logic t_ctl_oe;
    logic serr_oe;

    // Resolved wires, released lines float high
    wire logic [AD_W-1:0] ad;
    wire logic par;
    wire logic trdy_n;
    wire logic stop_n;
    wire logic devsel_n;
    wire logic serr_n;

    assign ad = t_ad_oe ? t_ad : (m_ad_oe ? m_ad : {AD_W{1'b1}});
    assign par = t_par_oe ? t_par : (m_par_oe ? m_par : 1'b1);
    assign trdy_n = t_ctl_oe ? t_trdy_n : 1'b1;
    assign stop_n = t_ctl_oe ? t_stop_n : 1'b1;
    assign devsel_n = t_ctl_oe ? t_devsel_n : 1'b1;
    assign serr_n = serr_oe ? 1'b0 : 1'b1;

    modport target (
        input ad,
        input cbe_n,
        input frame_n,
        input irdy_n,
        input par,
        output t_ad,
        output t_ad_oe,
        output t_par,
        output t_par_oe,
        output t_trdy_n,
        output t_stop_n,
        output t_devsel_n,
        output t_ctl_oe,
        output serr_oe
    );

    modport initiator (
        input ad,
        input par,
        input trdy_n,
        input stop_n,
        input devsel_n,
        input serr_n,
        output m_ad,
        output m_ad_oe,
        output cbe_n,
        output frame_n,
        output irdy_n,
        output m_par,
        output m_par_oe
    );

endinterface

`default_nettype wire

// ---- rtl/pci_initiator.sv ----
`timescale 1ns/1ps
`default_nettype none

module pci_initiator
    import pci_pkg::*;
#(
    parameter int LEN_W = BURST_W
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ce,
    pci_if.initiator bus,
    input wire logic start,
    input wire logic is_write,
    input wire logic [AD_W-1:0] addr,
    input wire logic [LEN_W-1:0] len,
    input wire logic [AD_W-1:0] wdata,
    output logic busy,
    output logic word_done,
    output logic [AD_W-1:0] rdata,
    output logic done,
    output logic stopped,
    output logic aborted,
    output logic rd_par_err,
    output logic serr_seen
);

    typedef enum logic [1:0] {I_IDLE = 2'b00, I_ADDR = 2'b01, I_DATA = 2'b11, I_TURN = 2'b10} istate_t;

    typedef struct packed {
        istate_t st;
        logic [AD_W-1:0] ad_out;
        logic ad_oe;
        logic [CBE_W-1:0] cbe_n;
        logic frame_n;
        logic irdy_n;
        logic par_out;
        logic par_oe;
        logic [LEN_W-1:0] left;
        logic wr;
        logic [ABORT_W-1:0] wait_cnt;
        logic rchk;
        logic busy;
        logic word_done;
        logic [AD_W-1:0] rdata;
        logic done;
        logic stopped;
        logic aborted;
        logic rperr;
        logic serr;
    } init_reg_t;

    init_reg_t r_reg;
    init_reg_t r_next;
    logic xfer;
    logic stop_seen;
    logic give_up;

    ////////////////////////////////////////////////////////////////
    always_comb
    begin
        r_next = r_reg;
        r_next.word_done = 1'b0;
        r_next.done = 1'b0;
        r_next.rchk = 1'b0;
        r_next.rperr = 1'b0;
        r_next.serr = !bus.serr_n;
        // RULE13: parity one clock late
        r_next.par_out = even_par(r_reg.ad_out, r_reg.cbe_n);
        r_next.par_oe = r_reg.ad_oe;
        if (r_reg.rchk)
        begin
            r_next.rperr = bus.par != even_par(r_reg.rdata, r_reg.cbe_n);
        end
        // RULE5: both ready move data
        xfer = !r_reg.irdy_n && !bus.trdy_n;
        stop_seen = !bus.stop_n;
        give_up = bus.devsel_n && (r_reg.wait_cnt == ABORT_CYC);
        unique case (r_reg.st)
            I_IDLE:
            begin
                if (start)
                begin
                    // RULE6: frame opens transfer
                    r_next.st = I_ADDR;
                    r_next.frame_n = 1'b0;
                    // RULE4: address on the lines
                    r_next.ad_out = addr;
                    r_next.ad_oe = 1'b1;
                    r_next.cbe_n = is_write ? CMD_IO_WR : CMD_IO_RD;
                    r_next.left = (len == '0) ? LEN_W'(1) : len;
                    r_next.wr = is_write;
                    r_next.busy = 1'b1;
                    r_next.stopped = 1'b0;
                    r_next.aborted = 1'b0;
                end
            end
            I_ADDR:
            begin
                r_next.st = I_DATA;
                r_next.cbe_n = BE_ALL;
                // RULE8: irdy with write data
                // RULE9: irdy ready for read
                r_next.irdy_n = 1'b0;
                r_next.ad_oe = r_reg.wr;
                r_next.ad_out = wdata;
                // RULE7: frame released on last
                r_next.frame_n = r_reg.left == LEN_W'(1);
                r_next.wait_cnt = '0;
            end
            I_DATA:
            begin
                if (bus.devsel_n)
                begin
                    r_next.wait_cnt = r_reg.wait_cnt + 1'b1;
                end
                if (xfer)
                begin
                    r_next.word_done = 1'b1;
                    r_next.left = r_reg.left - 1'b1;
                    r_next.ad_out = wdata;
                    if (!r_reg.wr)
                    begin
                        r_next.rdata = bus.ad;
                        r_next.rchk = 1'b1;
                    end
                end
                // RULE11: stop ends the transaction
                if (r_reg.frame_n && (xfer || stop_seen || give_up))
                begin
                    r_next.st = I_TURN;
                    r_next.irdy_n = 1'b1;
                    r_next.ad_oe = 1'b0;
                    r_next.done = 1'b1;
                    r_next.busy = 1'b0;
                    r_next.stopped = r_reg.stopped || (stop_seen && !xfer);
                    r_next.aborted = give_up && !xfer;
                end
                else if (stop_seen || give_up)
                begin
                    r_next.frame_n = 1'b1;
                    r_next.stopped = stop_seen;
                end
                else if (xfer && r_reg.left == LEN_W'(2))
                begin
                    r_next.frame_n = 1'b1;
                end
            end
            I_TURN:
            begin
                r_next.st = I_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // RULE1: one bus clock
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            r_reg <= '0;
            r_reg.st <= I_IDLE;
            r_reg.frame_n <= 1'b1;
            r_reg.irdy_n <= 1'b1;
            r_reg.cbe_n <= BE_ALL;
        end
        else if (ce)
        begin
            r_reg <= r_next;
        end
    end

    assign bus.m_ad = r_reg.ad_out;
    assign bus.m_ad_oe = r_reg.ad_oe;
    assign bus.cbe_n = r_reg.cbe_n;
    assign bus.frame_n = r_reg.frame_n;
    assign bus.irdy_n = r_reg.irdy_n;
    assign bus.m_par = r_reg.par_out;
    assign bus.m_par_oe = r_reg.par_oe;
    assign busy = r_reg.busy;
    assign word_done = r_reg.word_done;
    assign rdata = r_reg.rdata;
    assign done = r_reg.done;
    assign stopped = r_reg.stopped;
    assign aborted = r_reg.aborted;
    assign rd_par_err = r_reg.rperr;
    assign serr_seen = r_reg.serr;

endmodule

`default_nettype wire

// ---- dv/pci_link_sva.sv ----
`timescale 1ns/1ps
`default_nettype none

module pci_link_sva
    import pci_pkg::*;
#(
    parameter logic [AD_W-1:0] BASE = IO_BASE_DEF,
    parameter int DEPTH = MEM_DEPTH_DEF
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [AD_W-1:0] ad,
    input wire logic [CBE_W-1:0] cbe_n,
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic par,
    input wire logic trdy_n,
    input wire logic stop_n,
    input wire logic devsel_n,
    input wire logic t_ad_oe,
    input wire logic t_par_oe,
    input wire logic t_ctl_oe,
    input wire logic serr_oe
);
    localparam logic [AD_W-1:0] MASK = AD_W'(DEPTH * 4 - 1);

    wire logic decode_hit;
    assign decode_hit = (cbe_n == CMD_IO_RD || cbe_n == CMD_IO_WR) && ((ad & ~MASK) == BASE);

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////
    // Bus phases
    sequence addr_phase;
        $fell(frame_n);
    endsequence

    sequence good_addr_par;
        addr_phase ##1 (par == ^{$past(ad), $past(cbe_n)});
    endsequence

    sequence last_xfer;
        frame_n && !irdy_n && !trdy_n;
    endsequence

    ////////////////////////////////////////
    // Checks
    reset_float_a:
        assert property (!$past(resetn) |-> !t_ad_oe && !serr_oe && !t_ctl_oe && !t_par_oe)
        else $error("target drives lines after reset");
    devsel_decode_a:
        assert property (addr_phase ##0 decode_hit |=> !devsel_n && t_ctl_oe)
        else $error("no device select after own address");
    miss_released_a:
        assert property (addr_phase ##0 !decode_hit |=> (!t_ctl_oe && !t_ad_oe) [*2])
        else $error("target drives on foreign address");
    trdy_valid_a:
        assert property (!trdy_n |-> !devsel_n && stop_n && t_ctl_oe)
        else $error("target ready without select or with stop");
    par_even_a:
        assert property ($past(t_ad_oe) |-> t_par_oe && par == ^{$past(ad), $past(cbe_n)})
        else $error("target parity wrong");
    no_serr_a:
        assert property (good_addr_par |=> !serr_oe [*2])
        else $error("system error on good address parity");
    stop_hold_a:
        assert property (!stop_n && !frame_n |=> !stop_n && trdy_n)
        else $error("stop dropped before frame released");
    turn_release_a:
        assert property (last_xfer |=> devsel_n && t_ctl_oe ##1 !t_ctl_oe && !t_ad_oe)
        else $error("target not released after last transfer");
endmodule

`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import pci_pkg::*;

    localparam logic [AD_W-1:0] BASE = IO_BASE_DEF;
    localparam int DEPTH = MEM_DEPTH_DEF;
    localparam int UA_W = $clog2(DEPTH);
    logic ref_clk = 1'h0;
    logic resetn = 1'h0;
    logic ce = 1'h1;
    logic start = 1'h0;
    logic is_write = 1'h0;
    logic [AD_W-1:0] addr = 32'h0;
    logic [BURST_W-1:0] len = 4'h0;
    logic [AD_W-1:0] wdata = 32'h0;
    logic [AD_W-1:0] wbase = 32'h0;
    logic user_ready = 1'h1;
    logic [UA_W-1:0] user_addr = '0;
    logic busy, word_done, done, stopped, aborted, rd_par_err, serr_seen;
    logic write_strobe, addr_par_err, data_par_err;
    logic [AD_W-1:0] rdata, user_rdata;
    logic [AD_W-1:0] rd_q[$];
    int n_fail = 0;
    int check_count = 0;
    int wk = 0;
    int n_sel = 0;
    int n_strobe = 0;
    int n_perr = 0;

    pci_if bus ();

    pci_initiator #(.LEN_W(BURST_W)) pci_initiator_inst (.ref_clk, .resetn, .ce, .bus(bus.initiator), .start,
        .is_write, .addr, .len, .wdata, .busy, .word_done, .rdata, .done, .stopped, .aborted, .rd_par_err, .serr_seen);
    pci_target #(.BASE(BASE), .DEPTH(DEPTH)) pci_target_inst (.ref_clk, .resetn, .ce, .bus(bus.target), .user_ready,
        .user_addr, .user_rdata, .write_strobe, .addr_par_err, .data_par_err);
    pci_link_sva #(.BASE(BASE), .DEPTH(DEPTH)) pci_link_sva_inst (.ref_clk, .resetn, .ad(bus.ad), .cbe_n(bus.cbe_n),
        .frame_n(bus.frame_n), .irdy_n(bus.irdy_n), .par(bus.par), .trdy_n(bus.trdy_n), .stop_n(bus.stop_n),
        .devsel_n(bus.devsel_n), .t_ad_oe(bus.t_ad_oe), .t_par_oe(bus.t_par_oe), .t_ctl_oe(bus.t_ctl_oe),
        .serr_oe(bus.serr_oe));

    always #20 ref_clk = ~ref_clk;

    ////////////////////////////////////////
    // Write data feed and bus monitors
    always @(posedge ref_clk)
    begin
        if (start === 1'h1)
        begin
            wdata <= wbase;
        end
        else if (bus.frame_n === 1'h0 && bus.irdy_n === 1'h1)
        begin
            wk <= 0;
            wdata <= wbase + 32'h1;
        end
        else if (bus.irdy_n === 1'h0 && bus.trdy_n === 1'h0)
        begin
            wk <= wk + 1;
            wdata <= wbase + AD_W'(wk + 2);
        end
        if (resetn === 1'h1)
        begin
            if (bus.devsel_n === 1'h0)
                n_sel++;
            if (write_strobe === 1'h1)
                n_strobe++;
            if (word_done === 1'h1)
                rd_q.push_back(rdata);
            if (rd_par_err !== 1'h0 || data_par_err !== 1'h0 || addr_par_err !== 1'h0 || serr_seen !== 1'h0)
                n_perr++;
        end
    end

    ////////////////////////////////////////
    // Shared tasks
    task automatic check(input logic [AD_W-1:0] seen, input logic [AD_W-1:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic xact(input logic wr, input logic [AD_W-1:0] a, input int n, input logic [AD_W-1:0] sd,
        input int hold);
        int i;
        @(posedge ref_clk);
        start <= 1'h1;
        is_write <= wr;
        addr <= a;
        len <= BURST_W'(n);
        wbase <= sd;
        n_sel = 0;
        n_strobe = 0;
        n_perr = 0;
        rd_q.delete();
        @(posedge ref_clk);
        start <= 1'h0;
        @(posedge ref_clk);
        check(busy, 1'h1, "not busy after start");
        for (i = 0; i < hold; i++)
        begin
            @(posedge ref_clk);
            check(bus.trdy_n, 1'h1, "ready while user not ready");
        end
        user_ready <= 1'h1;
        for (i = 0; i < 100 && done !== 1'h1; i++)
            @(posedge ref_clk);
        if (done !== 1'h1)
        begin
            n_fail++;
            $display("unexpected at %0t: transaction hung", $time);
            wrap_up();
        end
        check(busy, 1'h0, "busy after done");
        repeat (2) @(posedge ref_clk);
        check(n_perr, 0, "parity error flagged");
    endtask

    task automatic peek(input int idx, input logic [AD_W-1:0] exp);
        @(posedge ref_clk);
        user_addr <= UA_W'(idx);
        repeat (2) @(posedge ref_clk);
        #1;
        check(user_rdata, exp, "stored word");
    endtask

    ////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        check(bus.t_ad_oe, 1'h0, "ad driven");
        check(bus.serr_oe, 1'h0, "serr driven");
        check(bus.t_ctl_oe, 1'h0, "controls driven");
        check(bus.ad, 32'hffffffff, "ad not floating");
        $display("reset test done");
    endtask

    task automatic t_write();
        xact(1'h1, BASE + 32'h4, 3, 32'h11110000, 0);
        check(n_strobe, 3, "write count");
        check(stopped, 1'h0, "write stopped");
        for (int i = 1; i < 4; i++)
            peek(i, 32'h11110000 + AD_W'(i - 1));
        $display("write test done");
    endtask

    task automatic t_read();
        xact(1'h0, BASE + 32'h8, 2, 32'h0, 0);
        check(rd_q.size(), 2, "read count");
        check(rd_q[0], 32'h11110001, "read word 0");
        check(rd_q[1], 32'h11110002, "read word 1");
        check(n_sel != 0, 1'h1, "no device select");
        $display("read test done");
    endtask

    task automatic t_slow();
        @(posedge ref_clk);
        user_ready <= 1'h0;
        xact(1'h1, BASE, 1, 32'h22220000, 6);
        check(n_strobe, 1, "slow write count");
        peek(0, 32'h22220000);
        $display("slow test done");
    endtask

    task automatic t_miss();
        xact(1'h0, BASE + 32'h100, 1, 32'h0, 0);
        check(n_sel, 0, "select on foreign address");
        check(aborted, 1'h1, "no abort");
        $display("miss test done");
    endtask

    task automatic t_stop();
        xact(1'h1, BASE + AD_W'((DEPTH - 2) * 4), 4, 32'h33330000, 0);
        check(stopped, 1'h1, "no stop at end");
        check(n_strobe, 2, "words before stop");
        peek(DEPTH - 2, 32'h33330000);
        peek(DEPTH - 1, 32'h33330001);
        $display("stop test done");
    endtask

    task automatic t_freeze();
        @(posedge ref_clk);
        ce <= 1'h0;
        start <= 1'h1;
        is_write <= 1'h1;
        addr <= BASE;
        len <= 4'h1;
        repeat (2) @(posedge ref_clk);
        check(bus.frame_n, 1'h1, "frame while frozen");
        check(busy, 1'h0, "busy while frozen");
        repeat (2) @(posedge ref_clk);
        start <= 1'h0;
        ce <= 1'h1;
        repeat (2) @(posedge ref_clk);
        $display("freeze test done");
    endtask

    task automatic t_mid_reset();
        @(posedge ref_clk);
        start <= 1'h1;
        is_write <= 1'h1;
        addr <= BASE + 32'h10;
        len <= 4'h3;
        @(posedge ref_clk);
        start <= 1'h0;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'h0;
        repeat (2) @(posedge ref_clk);
        #1;
        check(bus.t_ad_oe, 1'h0, "ad driven in reset");
        check(bus.t_ctl_oe, 1'h0, "controls driven in reset");
        check(bus.t_par_oe, 1'h0, "parity driven in reset");
        @(posedge ref_clk);
        resetn <= 1'h1;
        peek(0, 32'h0);
        $display("mid reset test done");
    endtask

    initial
    begin
        repeat (5) @(posedge ref_clk);
        resetn <= 1'h1;
        #1;
        t_reset();
        t_write();
        t_read();
        t_slow();
        t_miss();
        t_stop();
        t_freeze();
        t_mid_reset();
        wrap_up();
    end
endmodule

`default_nettype wire
